// File: core/converter_param_fallback_watchdog.sv
// Converter parameter bank with control-rights fallback watchdog
// Summary of operation
// RL1 - Cleared rights bit or lost cyclic traffic starts fallback handling
// RL2 - Fallback word mirrors control word; acts only while fallback applies; here ctrlWordOut keeps it after recovery until the next telegram
// RL3 - Fallback rights bit zero hands rights down, other bits ignored
// RL4 - Fallback rights bit one keeps rights and applies other bits
// RL5 - Cleared bit and lost traffic handled the same way
// RL6 - Timeout zero waits forever, rights never change
// RL7 - Nonzero timeout acts after that many tenths of a second
// RL8 - Good telegram with rights bit restarts timer, counting stops
// RL9 - Response waits programmed pause in ms after request, range 0-20
// RL10 - Band from 60 Hz to nominal must pass within limit seconds
// RL11 - Hours counter in hundredths advances only while pump runs
// RL12 - Hours stored at each error, read by index 0-253
// RL13 - History holds 254 entries, index 0 newest, 253 oldest
// RL14 - Warning bits shown one per bit, unused bits zero
// RL15 - Power-fail venting opens at vent-on, closes at vent-off frequency
// RL16 - Generator mode 0 blocks feedback, 1 allows it
// RL17 - Read-only code reports inserted bus module or none found
// RL18 - Catalogue text gives one ASCII char per index 0-17
// RL19 - DC current limit programmable in mA, default 9000
`timescale 1ns/1ps
module converter_param_fallback_watchdog
  import conv_param_pkg::*;
#(
  parameter logic [31:0]  TENTH_CYCLES = TENTH_CYC,
  parameter logic [31:0]  MS_CYCLES    = MS_CYC,
  parameter logic [31:0]  SEC_CYCLES   = SEC_CYC,
  parameter logic [31:0]  HOURS_CYCLES = HOURS_CYC,
  parameter logic [143:0] CATALOG_TEXT = "CAT-NO-0000-000000"  // Arbitrary text
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire param_req_type req,
  output param_rsp_type      rsp,
  input  wire logic          telegram,
  input  wire logic [15:0]   adapterCtrl,
  output logic [15:0]        ctrlWordOut,
  output logic               fallbackActive,
  output logic               rightsReleased,
  input  wire logic          requestDone,
  output logic               txStart,
  input  wire logic          startCmd,
  input  wire logic [15:0]   rotorHz,
  input  wire logic [15:0]   nominalSpeed,
  output logic               passTimeFault,
  input  wire logic          pumpActive,
  input  wire logic          errorLog,
  input  wire logic [15:0]   warnIn,
  input  wire logic          powerFailPin,
  input  wire logic [5:0]    outputFunctionSelect,
  input  wire logic [15:0]   upperFrequencyLimit,
  output logic               ventValve,
  output logic               feedbackEnable,
  output logic [15:0]        dcCurrentLimit,
  output logic [15:0]        systemPowerLimit,
  input  wire logic [31:0]   busModuleCode
);
  typedef enum logic [1:0] {HEALTHY, WAITING, APPLIED, RELEASED} fb_state_type;

  fb_state_type  state_r;
  param_rsp_type rsp_r;
  logic [15:0]   fbCtrl_r, pause_r, timeout_r, dcLimit_r, pwrLimit_r;
  logic [15:0]   ventOpen_r, ventClose_r, feedback_r, warn_r, ctrlOut_r;
  logic [31:0]   tenthCnt_r, msCnt_r, secCnt_r, hourCnt_r, hours_r;
  logic [15:0]   fbTenths_r, pauseLeft_r, passSecs_r;
  logic [3:0]    gapTenths_r;
  logic          pausing_r, txStart_r, passFault_r, vent_r;
  logic          pfMeta_r, pfSync_r;
  logic [31:0]   hist_r [0:253];
  logic [7:0]    wrPtr_r, histCount_r;
  logic          tenthTick, commLost, goodTlg, badTlg, inBand, wrOk;
  logic [8:0]    rdSum;
  logic [7:0]    rdAddr;

  assign tenthTick = (tenthCnt_r == TENTH_CYCLES - 32'h0000_0001);
  assign goodTlg   = telegram && adapterCtrl[RIGHTS_BIT];
  assign badTlg    = telegram && !adapterCtrl[RIGHTS_BIT];
  assign commLost  = (gapTenths_r == COMM_LOSS_TENTHS) && tenthTick;

  // Free tenth-second tick shared by watchdog and traffic gap monitor
  always_ff @(posedge clk) begin
    if (srst || tenthTick) begin
      tenthCnt_r <= 32'h0000_0000;
    end else begin
      tenthCnt_r <= tenthCnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || telegram) begin
      gapTenths_r <= 4'h0;
    end else if (tenthTick && gapTenths_r != COMM_LOSS_TENTHS) begin
      gapTenths_r <= gapTenths_r + 4'h1;
    end
  end

  // Fallback sequencing; a loss already in fallback is not re-armed
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= HEALTHY;
    end else begin
      unique case (state_r)
        HEALTHY: begin
          if (badTlg || (commLost && !goodTlg)) begin  // [RL1] [RL5]
            state_r <= WAITING;
          end
        end
        WAITING: begin
          if (goodTlg) begin  // [RL8]
            state_r <= HEALTHY;
          end else if (timeout_r != 16'h0000 && fbTenths_r >= timeout_r) begin  // [RL6] [RL7]
            state_r <= fbCtrl_r[RIGHTS_BIT] ? APPLIED : RELEASED;  // [RL3] [RL4]
          end
        end
        APPLIED, RELEASED: begin
          if (goodTlg) begin  // [RL8]
            state_r <= HEALTHY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_r != WAITING || goodTlg) begin
      fbTenths_r <= 16'h0000;  // [RL8]
    end else if (tenthTick && fbTenths_r != 16'hffff) begin
      fbTenths_r <= fbTenths_r + 16'h0001;  // [RL7]
    end
  end

  // Effective control word; fallback bits only drive it once applied
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlOut_r <= 16'h0000;
    end else if (state_r == APPLIED) begin
      ctrlOut_r <= fbCtrl_r;  // [RL2] [RL4]
    end else if (state_r == RELEASED) begin
      ctrlOut_r <= 16'h0000;  // [RL3]
    end else if (telegram) begin
      ctrlOut_r <= adapterCtrl;
    end
  end

  // Response pause, counted in whole milliseconds
  always_ff @(posedge clk) begin
    if (srst) begin
      pausing_r   <= 1'b0;
      pauseLeft_r <= 16'h0000;
      msCnt_r     <= 32'h0000_0000;
      txStart_r   <= 1'b0;
    end else begin
      txStart_r <= 1'b0;
      if (requestDone) begin
        pausing_r   <= (pause_r != 16'h0000);
        pauseLeft_r <= pause_r;
        msCnt_r     <= 32'h0000_0000;
        txStart_r   <= (pause_r == 16'h0000);  // [RL9]
      end else if (pausing_r) begin
        if (msCnt_r == MS_CYCLES - 32'h0000_0001) begin
          msCnt_r <= 32'h0000_0000;
          if (pauseLeft_r == 16'h0001) begin
            pausing_r <= 1'b0;
            txStart_r <= 1'b1;  // [RL9]
          end
          pauseLeft_r <= pauseLeft_r - 16'h0001;
        end else begin
          msCnt_r <= msCnt_r + 32'h0000_0001;
        end
      end
    end
  end

  // Critical band supervision; the fault holds until start is removed
  assign inBand = (rotorHz >= BAND_LOW_HZ) && (rotorHz < nominalSpeed);
  always_ff @(posedge clk) begin
    if (srst || !startCmd) begin
      secCnt_r    <= 32'h0000_0000;
      passSecs_r  <= 16'h0000;
      passFault_r <= 1'b0;
    end else if (inBand && !passFault_r) begin  // [RL10]
      if (secCnt_r == SEC_CYCLES - 32'h0000_0001) begin
        secCnt_r   <= 32'h0000_0000;
        passSecs_r <= passSecs_r + 16'h0001;
      end else begin
        secCnt_r <= secCnt_r + 32'h0000_0001;
      end
      passFault_r <= (passSecs_r >= RST_PASS_LIMIT);  // [RL10]
    end
  end

  // Operating hours; the partial interval is kept across pauses
  always_ff @(posedge clk) begin
    if (srst) begin
      hourCnt_r <= 32'h0000_0000;
      hours_r   <= 32'h0000_0000;
    end else if (pumpActive) begin  // [RL11]
      if (hourCnt_r == HOURS_CYCLES - 32'h0000_0001) begin
        hourCnt_r <= 32'h0000_0000;
        hours_r   <= hours_r + 32'h0000_0001;
      end else begin
        hourCnt_r <= hourCnt_r + 32'h0000_0001;
      end
    end
  end

  // History ring; no reset on the array so it maps to memory
  always_ff @(posedge clk) begin
    if (errorLog) begin
      hist_r[wrPtr_r] <= hours_r;  // [RL12]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r     <= 8'h00;
      histCount_r <= 8'h00;
    end else if (errorLog) begin
      wrPtr_r <= (wrPtr_r == HIST_DEPTH - 8'h01) ? 8'h00 : wrPtr_r + 8'h01;  // [RL13]
      if (histCount_r != HIST_DEPTH) begin
        histCount_r <= histCount_r + 8'h01;
      end
    end
  end

  // Index 0 is the slot just behind the write pointer
  assign rdSum  = {1'b0, wrPtr_r} + {1'b0, HIST_DEPTH} - 9'h001 - {1'b0, req.index};
  assign rdAddr = (rdSum >= {1'b0, HIST_DEPTH}) ? rdSum[7:0] - HIST_DEPTH : rdSum[7:0];  // [RL13]

  always_ff @(posedge clk) begin
    if (srst) begin
      warn_r <= 16'h0000;
    end else begin
      warn_r <= warnIn & WARN_MASK;  // [RL14]
    end
  end

  // Power fail arrives from a pin
  always_ff @(posedge clk) begin
    if (srst) begin
      pfMeta_r <= 1'b0;
      pfSync_r <= 1'b0;
    end else begin
      pfMeta_r <= powerFailPin;
      pfSync_r <= pfMeta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vent_r <= 1'b0;
    end else if (pfSync_r && (outputFunctionSelect == OUT_FUNC_VENT ||
                              outputFunctionSelect == OUT_FUNC_VENT2)) begin
      if (rotorHz <= ventClose_r) begin
        vent_r <= 1'b0;  // [RL15]
      end else if (rotorHz <= ventOpen_r) begin
        vent_r <= 1'b1;  // [RL15]
      end
    end else begin
      vent_r <= 1'b0;
    end
  end

  // Writes with range checks; out-of-range values are refused whole
  always_comb begin
    wrOk = 1'b0;
    unique case (req.num)
      P_FB_CTRL, P_FB_TIMEOUT: wrOk = (req.data[31:16] == 16'h0000);
      P_RSP_PAUSE:  wrOk = (req.data <= {16'h0000, MAX_RSP_PAUSE});
      P_DC_LIMIT:   wrOk = (req.data <= {16'h0000, MAX_DC_LIMIT});
      P_PWR_LIMIT:  wrOk = (req.data <= {16'h0000, MAX_PWR_LIMIT});
      P_VENT_OPEN, P_VENT_CLOSE: wrOk = (req.data <= {16'h0000, upperFrequencyLimit});
      P_FEEDBACK:   wrOk = (req.data <= 32'h0000_0001);
      default:      wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fbCtrl_r    <= RST_FB_CTRL;
      pause_r     <= RST_RSP_PAUSE;
      timeout_r   <= RST_FB_TIMEOUT;
      dcLimit_r   <= RST_DC_LIMIT;  // [RL19]
      pwrLimit_r  <= RST_PWR_LIMIT;
      ventOpen_r  <= RST_VENT_OPEN;
      ventClose_r <= RST_VENT_CLOSE;
      feedback_r  <= RST_FEEDBACK;
    end else if (req.valid && req.write && wrOk) begin
      unique case (req.num)
        P_FB_CTRL:    fbCtrl_r    <= req.data[15:0];
        P_RSP_PAUSE:  pause_r     <= req.data[15:0];
        P_FB_TIMEOUT: timeout_r   <= req.data[15:0];
        P_DC_LIMIT:   dcLimit_r   <= req.data[15:0];  // [RL19]
        P_PWR_LIMIT:  pwrLimit_r  <= req.data[15:0];
        P_VENT_OPEN:  ventOpen_r  <= req.data[15:0];
        P_VENT_CLOSE: ventClose_r <= req.data[15:0];
        P_FEEDBACK:   feedback_r  <= req.data[15:0];  // [RL16]
        default: ;
      endcase
    end
  end

  // One-cycle answer to every request
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= req.valid;
      rsp_r.err   <= 1'b0;
      rsp_r.data  <= 32'h0000_0000;
      if (req.valid && req.write) begin
        rsp_r.err <= !wrOk;
      end else if (req.valid) begin
        unique case (req.num)
          P_ERR_HOURS: begin
            rsp_r.err  <= (req.index >= HIST_DEPTH);
            if (req.index < histCount_r) begin
              rsp_r.data <= hist_r[rdAddr];  // [RL12] [RL13]
            end
          end
          P_FB_CTRL:     rsp_r.data <= {16'h0000, fbCtrl_r};
          P_RSP_PAUSE:   rsp_r.data <= {16'h0000, pause_r};
          P_FB_TIMEOUT:  rsp_r.data <= {16'h0000, timeout_r};
          P_PASS_LIMIT:  rsp_r.data <= {16'h0000, RST_PASS_LIMIT};
          P_OP_HOURS:    rsp_r.data <= hours_r;  // [RL11]
          P_DC_LIMIT:    rsp_r.data <= {16'h0000, dcLimit_r};
          P_PWR_LIMIT:   rsp_r.data <= {16'h0000, pwrLimit_r};
          P_WARNINGS:    rsp_r.data <= {16'h0000, warn_r};  // [RL14]
          P_VENT_OPEN:   rsp_r.data <= {16'h0000, ventOpen_r};
          P_VENT_CLOSE:  rsp_r.data <= {16'h0000, ventClose_r};
          P_FEEDBACK:    rsp_r.data <= {16'h0000, feedback_r};
          P_MODULE_TYPE: rsp_r.data <= busModuleCode;  // [RL17]
          P_CATALOG: begin
            rsp_r.err <= (req.index >= TEXT_LEN);
            if (req.index < TEXT_LEN) begin
              rsp_r.data <= {24'h00_0000, CATALOG_TEXT[8'(143 - 8 * req.index) -: 8]};  // [RL18]
            end
          end
          default:       rsp_r.err <= 1'b1;
        endcase
      end
    end
  end

  assign rsp              = rsp_r;
  assign ctrlWordOut      = ctrlOut_r;
  assign fallbackActive   = (state_r == APPLIED);
  assign rightsReleased   = (state_r == RELEASED);
  assign txStart          = txStart_r;
  assign passTimeFault    = passFault_r;
  assign ventValve        = vent_r;
  assign feedbackEnable   = feedback_r[0];  // [RL16]
  assign dcCurrentLimit   = dcLimit_r;
  assign systemPowerLimit = pwrLimit_r;

  sequence s_lost_rights;
    state_r == HEALTHY && badTlg;
  endsequence

  sequence s_wait_expired;
    state_r == WAITING && !goodTlg && timeout_r != 16'h0000 && fbTenths_r >= timeout_r;
  endsequence

  a_fallback_entry: assert property (@(posedge clk) disable iff (srst)  // [RL1]
    s_lost_rights |=> state_r == WAITING)
    else $error("Cleared rights bit did not start fallback");
  a_zero_timeout: assert property (@(posedge clk) disable iff (srst)  // [RL6]
    state_r == WAITING && timeout_r == 16'h0000 && !goodTlg |=> state_r == WAITING)
    else $error("Fallback acted with zero timeout");
  a_expiry_keep: assert property (@(posedge clk) disable iff (srst)  // [RL4]
    s_wait_expired ##0 fbCtrl_r[RIGHTS_BIT] |=> ##1 fallbackActive && ctrlWordOut == fbCtrl_r)
    else $error("Fallback word not applied at expiry");
  a_expiry_release: assert property (@(posedge clk) disable iff (srst)  // [RL3]
    s_wait_expired ##0 !fbCtrl_r[RIGHTS_BIT] |=> rightsReleased ##1 ctrlWordOut == 16'h0000)
    else $error("Rights not released at expiry");
  a_early_hold: assert property (@(posedge clk) disable iff (srst)  // [RL7]
    state_r == WAITING && fbTenths_r < timeout_r |=> !fallbackActive && !rightsReleased)
    else $error("Fallback acted before timeout");
  a_good_restart: assert property (@(posedge clk) disable iff (srst)  // [RL8]
    goodTlg |=> state_r == HEALTHY && fbTenths_r == 16'h0000)
    else $error("Good telegram did not restore control");
  a_zero_pause: assert property (@(posedge clk) disable iff (srst)  // [RL9]
    requestDone && pause_r == 16'h0000 |=> txStart)
    else $error("Zero pause did not answer at once");
  a_pause_quiet: assert property (@(posedge clk) disable iff (srst)  // [RL9]
    requestDone && pause_r != 16'h0000 |=> !txStart [*2])
    else $error("Response sent before pause");
  a_warn_unused: assert property (@(posedge clk) disable iff (srst)  // [RL14]
    1'b1 |=> warn_r == ($past(warnIn) & WARN_MASK))
    else $error("Warning bits not shown as masked input");
  a_hours_idle: assert property (@(posedge clk) disable iff (srst)  // [RL11]
    !pumpActive |=> $stable(hours_r))
    else $error("Hours advanced while pump idle");
  a_feedback_mode: assert property (@(posedge clk) disable iff (srst)  // [RL16]
    req.valid && req.write && req.num == P_FEEDBACK && wrOk |=> feedbackEnable == $past(req.data[0]))
    else $error("Generator mode not applied");
endmodule : converter_param_fallback_watchdog

// File: core/conv_param_pkg.sv
// Constants and carrier types for the converter parameter bank
package conv_param_pkg;
  localparam logic [9:0] P_ERR_HOURS   = 10'h0b0;
  localparam logic [9:0] P_FB_CTRL     = 10'h0b3;
  localparam logic [9:0] P_RSP_PAUSE   = 10'h0b4;
  localparam logic [9:0] P_FB_TIMEOUT  = 10'h0b6;
  localparam logic [9:0] P_PASS_LIMIT  = 10'h0b7;
  localparam logic [9:0] P_OP_HOURS    = 10'h0b8;
  localparam logic [9:0] P_DC_LIMIT    = 10'h0b9;
  localparam logic [9:0] P_PWR_LIMIT   = 10'h0c6;
  localparam logic [9:0] P_WARNINGS    = 10'h0e3;
  localparam logic [9:0] P_VENT_OPEN   = 10'h0f7;
  localparam logic [9:0] P_VENT_CLOSE  = 10'h0f8;
  localparam logic [9:0] P_FEEDBACK    = 10'h0f9;
  localparam logic [9:0] P_MODULE_TYPE = 10'h129;
  localparam logic [9:0] P_CATALOG     = 10'h138;

  localparam logic [15:0] RST_FB_CTRL    = 16'h0000;
  localparam logic [15:0] RST_RSP_PAUSE  = 16'h000a;
  localparam logic [15:0] RST_FB_TIMEOUT = 16'h0064;
  localparam logic [15:0] RST_PASS_LIMIT = 16'h0708;
  localparam logic [15:0] RST_DC_LIMIT   = 16'h2328;
  localparam logic [15:0] RST_PWR_LIMIT  = 16'h0960;
  localparam logic [15:0] RST_VENT_OPEN  = 16'h03e7;
  localparam logic [15:0] RST_VENT_CLOSE = 16'h0005;
  localparam logic [15:0] RST_FEEDBACK   = 16'h0000;

  localparam logic [15:0] MAX_RSP_PAUSE = 16'h0014;
  localparam logic [15:0] MAX_DC_LIMIT  = 16'h2710;
  localparam logic [15:0] MAX_PWR_LIMIT = 16'h0960;
  localparam logic [15:0] WARN_MASK     = 16'h78cf;
  localparam logic [15:0] BAND_LOW_HZ   = 16'h003c;
  localparam int          RIGHTS_BIT    = 10;
  localparam logic [7:0]  HIST_DEPTH    = 8'hfe;
  localparam logic [7:0]  TEXT_LEN      = 8'h12;
  localparam logic [3:0]  COMM_LOSS_TENTHS = 4'h5;
  localparam logic [5:0]  OUT_FUNC_VENT  = 6'h19;
  localparam logic [5:0]  OUT_FUNC_VENT2 = 6'h29;

  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TENTH_S_MS     = 100;
  localparam int unsigned PAUSE_UNIT_MS  = 1;
  localparam int unsigned PASS_UNIT_S    = 1;
  localparam int unsigned HOURS_UNIT_S   = 36;
  localparam int unsigned TENTH_CYC = CLK_HZ / 1000 * TENTH_S_MS;
  localparam int unsigned MS_CYC    = CLK_HZ / 1000 * PAUSE_UNIT_MS;
  localparam int unsigned SEC_CYC   = CLK_HZ * PASS_UNIT_S;
  localparam int unsigned HOURS_CYC = CLK_HZ * HOURS_UNIT_S;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  num;
    logic [7:0]  index;
    logic [31:0] data;
  } param_req_type;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] data;
  } param_rsp_type;
endpackage : conv_param_pkg

// File: testbench/adapter_model.sv
// Bus adapter model that sends cyclic control telegrams
`timescale 1ns/1ps
module adapter_model #(
  parameter int PERIOD = 20
) (
  input  wire logic        clk,
  input  wire logic        running,
  input  wire logic [15:0] word,
  output logic             telegram,
  output logic [15:0]      adapterCtrl
);
  int cnt = 0;
  initial telegram = 1'b0;
  initial adapterCtrl = 16'h0000;
  // Word toggles between telegrams, so a stale value never looks fresh
  always @(posedge clk) begin
    cnt <= (cnt == PERIOD - 1 || !running) ? 0 : cnt + 1;
    telegram <= running && cnt == PERIOD - 1;
    adapterCtrl <= (running && cnt == PERIOD - 1) ? word : ~adapterCtrl;
  end
endmodule : adapter_model

// File: testbench/tb_top.sv
// Self-checking bench for the converter parameter bank
`timescale 1ns/1ps
module tb_top;
  import conv_param_pkg::*;
  localparam int TC = 10;
  localparam int MC = 4;
  localparam int SC = 4;
  localparam int HC = 8;
  localparam logic [143:0] CAT = "TESTCATALOGUE-0123";  // Arbitrary text
  localparam logic [9:0] NUMS [9] = '{P_FB_CTRL, P_RSP_PAUSE, P_FB_TIMEOUT, P_PASS_LIMIT,
    P_DC_LIMIT, P_PWR_LIMIT, P_VENT_OPEN, P_VENT_CLOSE, P_FEEDBACK};
  localparam logic [15:0] RSTS [9] = '{RST_FB_CTRL, RST_RSP_PAUSE, RST_FB_TIMEOUT,
    RST_PASS_LIMIT, RST_DC_LIMIT, RST_PWR_LIMIT, RST_VENT_OPEN, RST_VENT_CLOSE, RST_FEEDBACK};
  localparam int PS [3] = '{0, 1, 20};
  logic clk = 0, srst = 1, requestDone = 0, startCmd = 0, pumpActive = 0;
  logic errorLog = 0, powerFailPin = 0, running = 0;
  logic [15:0] rotorHz = 0, nominalSpeed = 16'h0258, warnIn = 0, upLim = 16'h03e8;
  logic [15:0] adWord = 16'h0400, adapterCtrl, ctrlWordOut, dcCurrentLimit, systemPowerLimit;
  logic [5:0]  outputFunctionSelect = 0;
  logic [31:0] busModuleCode = 0, hPrev;
  logic telegram, fallbackActive, rightsReleased, txStart, passTimeFault;
  logic ventValve, feedbackEnable;
  param_req_type req = '0;
  param_rsp_type rsp, r;
  int num_errors = 0, n_checks = 0, cyc = 0, n;
  logic [31:0] mdl [int];
  logic [31:0] hist [$];

  adapter_model #(.PERIOD(20)) u_adapter (.clk(clk), .running(running), .word(adWord),
    .telegram(telegram), .adapterCtrl(adapterCtrl));
  converter_param_fallback_watchdog #(.TENTH_CYCLES(TC), .MS_CYCLES(MC), .SEC_CYCLES(SC),
    .HOURS_CYCLES(HC), .CATALOG_TEXT(CAT)) u_dut (.clk(clk), .srst(srst), .req(req),
    .rsp(rsp), .telegram(telegram), .adapterCtrl(adapterCtrl), .ctrlWordOut(ctrlWordOut),
    .fallbackActive(fallbackActive), .rightsReleased(rightsReleased),
    .requestDone(requestDone), .txStart(txStart), .startCmd(startCmd), .rotorHz(rotorHz),
    .nominalSpeed(nominalSpeed), .passTimeFault(passTimeFault), .pumpActive(pumpActive),
    .errorLog(errorLog), .warnIn(warnIn), .powerFailPin(powerFailPin),
    .outputFunctionSelect(outputFunctionSelect), .upperFrequencyLimit(upLim),
    .ventValve(ventValve), .feedbackEnable(feedbackEnable), .dcCurrentLimit(dcCurrentLimit),
    .systemPowerLimit(systemPowerLimit), .busModuleCode(busModuleCode));

  initial forever #10 clk = ~clk;

  // Ceiling well above the longest path through the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("MISMATCH cycleLimit exp done got hang");
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic chkB(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", what, exp, got);
    end
  endtask : chkB

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic legal(input logic [9:0] num, input logic [31:0] v);
    if (v[31:16] != 16'h0000) return 1'b0;
    case (num)
      P_FB_CTRL, P_FB_TIMEOUT: return 1'b1;
      P_RSP_PAUSE: return v[15:0] <= MAX_RSP_PAUSE;
      P_DC_LIMIT: return v[15:0] <= MAX_DC_LIMIT;
      P_PWR_LIMIT: return v[15:0] <= MAX_PWR_LIMIT;
      P_FEEDBACK: return v[15:0] <= 16'h0001;
      P_VENT_OPEN, P_VENT_CLOSE: return v[15:0] <= upLim;
      default: return 1'b0;
    endcase
  endfunction : legal

  // Request held one cycle; the answer must stand in the following cycle
  task automatic acc(input logic w, input logic [9:0] num, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    #1;
    req = '{1'b1, w, num, idx, d};
    tick(1);
    req.valid = 1'b0;
    r = rsp;
    chkB("rspValid", 1'b1, r.valid);
  endtask : acc

  task automatic rd(input logic [9:0] num, input logic [7:0] idx, input logic [31:0] exp,
                    input logic err);
    acc(1'b0, num, idx, 32'h0000_0000);
    chkB("rdErr", err, r.err);
    chk("rdData", exp, r.data);
  endtask : rd

  task automatic wr(input logic [9:0] num, input logic [31:0] d);
    logic ok;
    ok = legal(num, d);
    acc(1'b1, num, 8'h00, d);
    chkB("wrErr", !ok, r.err);
    if (ok) mdl[num] = d;
  endtask : wr

  task automatic rdAll();
    for (int i = 0; i < 9; i++) rd(NUMS[i], 8'h00, mdl[NUMS[i]], 1'b0);
    chk("dcLimit", mdl[P_DC_LIMIT], {16'h0000, dcCurrentLimit});
    chk("pwrLimit", mdl[P_PWR_LIMIT], {16'h0000, systemPowerLimit});
  endtask : rdAll

  task automatic fallback(input logic [15:0] t, input logic b10, input logic loss);
    logic [15:0] w;
    w = {5'($urandom), b10, 10'($urandom)};
    wr(P_FB_TIMEOUT, {16'h0000, t});
    wr(P_FB_CTRL, {16'h0000, w});
    if (loss) running = 1'b0;
    else begin
      adWord = {5'($urandom), 1'b0, 10'($urandom)};
      @(posedge clk iff (telegram === 1'b1 && adapterCtrl === adWord));
      #1;
    end
    n = 0;
    while (fallbackActive !== 1'b1 && rightsReleased !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    if (t == 0) chkB("noFallback", 1'b1, n == 1000);
    else begin
      chkB("delayLow", 1'b1, loss || n >= (t - 1) * TC);
      chkB("delayHigh", 1'b1, n <= (loss ? (t + 6) * TC + 30 : t * TC + 3));
      tick(2);
      chkB("applied", b10, fallbackActive);
      chkB("released", !b10, rightsReleased);
      chk("ctrlOut", b10 ? {16'h0000, w} : 32'h0000_0000, {16'h0000, ctrlWordOut});
    end
    running = 1'b1;
    adWord = {5'($urandom), 1'b1, 10'($urandom)};
    repeat (2) @(posedge clk iff (telegram === 1'b1 && adapterCtrl === adWord));
    tick(2);
    chkB("healthy", 1'b0, fallbackActive | rightsReleased);
    chk("ctrlOut", {16'h0000, adWord}, {16'h0000, ctrlWordOut});
  endtask : fallback

  initial begin
    void'($urandom(32'he9d9));
    tick(4);
    srst = 1'b0;
    running = 1'b1;
    for (int i = 0; i < 9; i++) mdl[NUMS[i]] = {16'h0000, RSTS[i]};
    rdAll();
    wr(P_FEEDBACK, 32'h0000_0001);
    tick(1);
    chkB("feedback", 1'b1, feedbackEnable);
    wr(P_FEEDBACK, 32'h0000_0002);
    wr(P_FEEDBACK, 32'h0000_0000);
    tick(1);
    chkB("feedback", 1'b0, feedbackEnable);
    wr(P_DC_LIMIT, 32'($urandom_range(10000)));
    wr(P_DC_LIMIT, 32'h0000_2711);
    wr(P_PWR_LIMIT, 32'h0000_0961);
    wr(P_VENT_OPEN, 32'h0000_03e9);
    wr(P_VENT_CLOSE, 32'h0001_0003);
    wr(P_OP_HOURS, 32'h0000_0001);
    wr(P_PASS_LIMIT, 32'h0000_0001);
    wr(P_MODULE_TYPE, 32'h0000_0001);
    rd(10'h3ff, 8'h00, 32'h0000_0000, 1'b1);
    tick(1);
    rdAll();
    for (int k = 0; k < 3; k++) begin
      wr(P_RSP_PAUSE, PS[k]);
      requestDone = 1'b1;
      tick(1);
      requestDone = 1'b0;
      n = 0;
      while (txStart !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk("pauseCycles", PS[k] * MC, n);
      tick(1);
      chkB("txPulse", 1'b0, txStart);
    end
    wr(P_RSP_PAUSE, 32'h0000_0015);
    fallback(16'h0003, 1'b1, 1'b0);
    fallback(16'h0003, 1'b0, 1'b0);
    fallback(16'h0002, 1'b1, 1'b1);
    fallback(16'h0000, 1'b1, 1'b0);
    hPrev = 0;
    for (int k = 0; k < 2; k++) begin
      pumpActive = 1'b1;
      tick(5 * HC);
      pumpActive = 1'b0;
      tick(2);
      acc(1'b0, P_OP_HOURS, 8'h00, 32'h0000_0000);
      chkB("hoursRun", 1'b1, r.data >= hPrev + 4 && r.data <= hPrev + 5);
      hPrev = r.data;
      tick(8 * HC);
      rd(P_OP_HOURS, 8'h00, hPrev, 1'b0);
      errorLog = 1'b1;
      tick(1);
      errorLog = 1'b0;
      hist.push_front(hPrev);
    end
    foreach (hist[i]) rd(P_ERR_HOURS, 8'(i), hist[i], 1'b0);
    rd(P_ERR_HOURS, HIST_DEPTH, 32'h0000_0000, 1'b1);
    repeat (3) begin
      warnIn = 16'($urandom);
      busModuleCode = $urandom;
      tick(3);
      rd(P_WARNINGS, 8'h00, {16'h0000, warnIn & WARN_MASK}, 1'b0);
      rd(P_MODULE_TYPE, 8'h00, busModuleCode, 1'b0);
    end
    for (int i = 0; i < 19; i++) rd(P_CATALOG, 8'(i), i < 18 ? {24'h0, CAT[143 - 8 * i -: 8]} : 0, i >= 18);
    startCmd = 1'b1;
    rotorHz = 16'h0064;
    tick(int'(RST_PASS_LIMIT) * SC - 2 * SC);
    chkB("passFault", 1'b0, passTimeFault);
    tick(4 * SC);
    chkB("passFault", 1'b1, passTimeFault);
    startCmd = 1'b0;
    tick(3);
    chkB("passFault", 1'b0, passTimeFault);
    powerFailPin = 1'b1;
    for (int k = 0; k < 3; k++) begin
      outputFunctionSelect = k == 0 ? OUT_FUNC_VENT : (k == 1 ? OUT_FUNC_VENT2 : 6'h00);
      rotorHz = 16'h01f4;
      tick(6);
      chkB("ventOpen", k < 2, ventValve);
      rotorHz = 16'h0005;
      tick(6);
      chkB("ventClose", 1'b0, ventValve);
    end
    close_out();
  end
endmodule : tb_top
